// ==== hdl/analog_trim_cfg.svh ====
/*
 * Offsets, field positions, reset values and widths of the analog trim and
 * test register bank. Included by the bank and its short supervisor; holds
 * definitions only.
 */
`ifndef ANALOG_TRIM_CFG_SVH
`define ANALOG_TRIM_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_SPARE_A        8'h19
`define OFS_REF_TRIM       8'h1a
`define OFS_SPARE_B        8'h1b
`define OFS_PLL_CTRL       8'h1c
`define OFS_PLL_CURRENT    8'h1d
`define OFS_PLL_DETECTOR   8'h1e
`define OFS_REG_SHORT      8'h1f
`define OFS_UV_SELECT      8'h20
`define OFS_LINE_TEST      8'h21
`define OFS_PD_OVERRIDE    8'h22
`define BANK_DEPTH         10
`define BANK_IDX_W         4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_SPARE_A        8'h00
`define RST_REF_TRIM       8'h40
`define RST_SPARE_B        8'h00
`define RST_PLL_CTRL       8'h10
`define RST_PLL_CURRENT    8'h00
`define RST_PLL_DETECTOR   8'h00
`define RST_REG_SHORT      8'h00
`define RST_UV_SELECT      8'h00
`define RST_LINE_TEST      8'h03
`define RST_PD_OVERRIDE    8'h00
`define RST_UNMAPPED_READ  8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_PLL_DIV_RST_N  4
`define BIT_PLL_CUR_TEST   1
`define BIT_PLL_FREERUN    0
`define BIT_PLL_DET_PD     0
`define BIT_SHORT_FLAG_N   4
`define BIT_AUTO_SD_DIS    0
`define BIT_UV_THRESHOLD   1
`define BIT_UV_REFERENCE   0
`define BIT_LOAD_B0        3
`define BIT_LOAD_B1        2
`define BIT_SLEW_B0        1
`define BIT_SLEW_B1        0
`define MSB_COMMON_TRIM    3
`define LSB_COMMON_TRIM    0
`define MSB_BANDGAP_TRIM   7
`define LSB_BANDGAP_TRIM   4
`define MSB_PD_OVERRIDE    5
`define LSB_PD_OVERRIDE    0

`endif

// ==== hdl/analog_trim_pkg.sv ====
/*
 * Types shared by the analog trim register bank and its short supervisor.
 * Assumes the constants header is included by each user.
 */
package analog_trim_pkg;

	// ------------------------------------------------------------------
	// Host access request
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic       wr_en;
		logic       rd_en;
		logic [7:0] wr_data;
	} reg_req_t;

	// ------------------------------------------------------------------
	// Analog control outputs
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       pll_divider_reset_n;
		logic       pll_current_test_enable;
		logic       pll_fast_freerun_select;
		logic [7:0] pll_test_current_code;
		logic       pll_detector_test_powerdown;
		logic       undervoltage_threshold_select;
		logic       undervoltage_reference_select;
		logic       first_stage_load_bit0;
		logic       first_stage_load_bit1;
		logic       slew_rate_bit0;
		logic       slew_rate_bit1;
		logic [3:0] common_voltage_trim;
		logic [3:0] bandgap_trim;
		logic [5:0] powerdown_override;
	} analog_ctrl_t;

	// ------------------------------------------------------------------
	// Regulator short supervisor states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		SC_RUN  = 2'b01,
		SC_SHUT = 2'b10
	} short_state_t;

endpackage : analog_trim_pkg

// ==== hdl/regulator_short_guard.sv ====
/*
 * Regulator short supervisor: reports the short flag and powers the
 * regulator down on a short unless automatic shutdown is disabled.
 * Assumes short_detect is synchronous to clk_sys.
 */
`timescale 1ns/10ps
`include "analog_trim_cfg.svh"

module regulator_short_guard (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic short_detect,
	input  wire logic auto_shutdown_disable,
	output logic      regulator_short_flag_n_r,
	output logic      regulator_powerdown_r
);

	// ------------------------------------------------------------------
	// Shutdown sequencing
	// ------------------------------------------------------------------
	analog_trim_pkg::short_state_t state_r;
	analog_trim_pkg::short_state_t state_nxt;

	// Latched: a short that clears by itself does not restart the regulator
	wire trip    = short_detect & ~auto_shutdown_disable;
	wire release_sd = auto_shutdown_disable;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			analog_trim_pkg::SC_RUN: begin
				if (trip)
					state_nxt = analog_trim_pkg::SC_SHUT;
			end
			analog_trim_pkg::SC_SHUT: begin
				if (release_sd)
					state_nxt = analog_trim_pkg::SC_RUN;
			end
			default: state_nxt = analog_trim_pkg::SC_RUN;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_r                  <= analog_trim_pkg::SC_RUN;
			regulator_powerdown_r    <= 1'b0;
			regulator_short_flag_n_r <= 1'b0;
		end else begin
			state_r                  <= state_nxt;
			regulator_powerdown_r    <= (state_nxt == analog_trim_pkg::SC_SHUT);
			regulator_short_flag_n_r <= ~short_detect;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	chk_auto_shutdown_trip: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		(short_detect && !auto_shutdown_disable) |=> regulator_powerdown_r
	) else $error("Short did not power down the regulator");

	chk_shutdown_disabled: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		auto_shutdown_disable |=> !regulator_powerdown_r
	) else $error("Regulator powered down while shutdown disabled");

	chk_short_flag_track: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		1'b1 |=> (regulator_short_flag_n_r == !$past(short_detect))
	) else $error("Short flag does not follow the detector");

endmodule : regulator_short_guard

// ==== hdl/analog_trim_bank.sv ====
/*
 * Byte-wide analog trim and test register bank at offsets 0x19..0x22.
 * Holds the trim codes, PLL test controls, regulator short handling,
 * under-voltage test selects, line driver test bits and power-down
 * overrides, and drives them onto the analog controls.
 * Assumes the device's serial control port decodes host transactions into
 * single-cycle byte read and write requests synchronous to clk_sys.
 */
`timescale 1ns/10ps
`include "analog_trim_cfg.svh"

module analog_trim_bank (
	input  wire logic                          clk_sys,
	input  wire logic                          sys_rst,
	input  wire analog_trim_pkg::reg_req_t     reg_req,
	input  wire logic                          short_detect,
	output logic [7:0]                         reg_rd_data_r,
	output logic                               reg_rd_valid_r,
	output logic                               reg_hit_r,
	output analog_trim_pkg::analog_ctrl_t      analog_ctrl_r,
	output logic                               regulator_powerdown_r
);

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	function automatic logic in_bank(input logic [7:0] addr);
		in_bank = (addr >= `OFS_SPARE_A) && (addr <= `OFS_PD_OVERRIDE);
	endfunction : in_bank

	function automatic logic [`BANK_IDX_W-1:0] bank_index(input logic [7:0] addr);
		logic [7:0] diff;
		diff       = addr - `OFS_SPARE_A;
		bank_index = diff[`BANK_IDX_W-1:0];
	endfunction : bank_index

	function automatic logic [7:0] reset_value(input int idx);
		logic [7:0] v;
		v = 8'h00;
		case (idx)
			0:       v = `RST_SPARE_A;
			1:       v = `RST_REF_TRIM;
			2:       v = `RST_SPARE_B;
			3:       v = `RST_PLL_CTRL;
			4:       v = `RST_PLL_CURRENT;
			5:       v = `RST_PLL_DETECTOR;
			6:       v = `RST_REG_SHORT;
			7:       v = `RST_UV_SELECT;
			8:       v = `RST_LINE_TEST;
			9:       v = `RST_PD_OVERRIDE;
			default: v = 8'h00;
		endcase
		reset_value = v;
	endfunction : reset_value

	wire                    req_hit  = in_bank(reg_req.addr);
	wire [`BANK_IDX_W-1:0]  req_idx  = bank_index(reg_req.addr);
	wire                    wr_hit   = reg_req.wr_en & req_hit;
	wire                    rd_hit   = reg_req.rd_en & req_hit;
	wire                    rd_any   = reg_req.rd_en;

	wire [`BANK_IDX_W-1:0]  idx_short = bank_index(`OFS_REG_SHORT);
	wire [`BANK_IDX_W-1:0]  idx_pll   = bank_index(`OFS_PLL_CTRL);

	// ------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------
	logic [7:0] bank_r   [`BANK_DEPTH];
	logic [7:0] bank_nxt [`BANK_DEPTH];

	// Every bit, reserved ones included, stores what the host writes
	always_comb begin
		for (int i = 0; i < `BANK_DEPTH; i++) begin
			bank_nxt[i] = bank_r[i];
			if (wr_hit && (req_idx == i[`BANK_IDX_W-1:0]))
				bank_nxt[i] = reg_req.wr_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < `BANK_DEPTH; i++) begin
			if (sys_rst)
				bank_r[i] <= reset_value(i);
			else
				bank_r[i] <= bank_nxt[i];
		end
	end

	// ------------------------------------------------------------------
	// Field views of the next register values
	// ------------------------------------------------------------------
	wire [7:0] ref_trim_nxt  = bank_nxt[1];
	wire [7:0] pll_ctrl_nxt  = bank_nxt[3];
	wire [7:0] pll_cur_nxt   = bank_nxt[4];
	wire [7:0] pll_det_nxt   = bank_nxt[5];
	wire [7:0] reg_short_nxt = bank_nxt[6];
	wire [7:0] uv_sel_nxt    = bank_nxt[7];
	wire [7:0] line_nxt      = bank_nxt[8];
	wire [7:0] pd_ovr_nxt    = bank_nxt[9];

	wire test_mode_nxt = pll_ctrl_nxt[`BIT_PLL_CUR_TEST];

	// ------------------------------------------------------------------
	// Analog control outputs
	// ------------------------------------------------------------------
	// Built from the next values so the controls move on the same edge
	// as the register, with no extra cycle of lag.
	analog_trim_pkg::analog_ctrl_t ctrl_nxt;

	always_comb begin
		ctrl_nxt = '0;
		ctrl_nxt.pll_divider_reset_n           = pll_ctrl_nxt[`BIT_PLL_DIV_RST_N];
		ctrl_nxt.pll_current_test_enable       = test_mode_nxt;
		ctrl_nxt.pll_fast_freerun_select       = pll_ctrl_nxt[`BIT_PLL_FREERUN];
		// Outside test mode the current DAC sees zero, not a stale code
		ctrl_nxt.pll_test_current_code         = test_mode_nxt ? pll_cur_nxt : 8'h00;
		ctrl_nxt.pll_detector_test_powerdown   = test_mode_nxt &
			pll_det_nxt[`BIT_PLL_DET_PD];
		ctrl_nxt.undervoltage_threshold_select = uv_sel_nxt[`BIT_UV_THRESHOLD];
		ctrl_nxt.undervoltage_reference_select = uv_sel_nxt[`BIT_UV_REFERENCE];
		ctrl_nxt.first_stage_load_bit0         = line_nxt[`BIT_LOAD_B0];
		ctrl_nxt.first_stage_load_bit1         = line_nxt[`BIT_LOAD_B1];
		ctrl_nxt.slew_rate_bit0                = line_nxt[`BIT_SLEW_B0];
		ctrl_nxt.slew_rate_bit1                = line_nxt[`BIT_SLEW_B1];
		ctrl_nxt.common_voltage_trim           =
			ref_trim_nxt[`MSB_COMMON_TRIM:`LSB_COMMON_TRIM];
		ctrl_nxt.bandgap_trim                  =
			ref_trim_nxt[`MSB_BANDGAP_TRIM:`LSB_BANDGAP_TRIM];
		ctrl_nxt.powerdown_override            =
			pd_ovr_nxt[`MSB_PD_OVERRIDE:`LSB_PD_OVERRIDE];
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			analog_ctrl_r <= '0;
			analog_ctrl_r.pll_divider_reset_n <= 1'(`RST_PLL_CTRL >> `BIT_PLL_DIV_RST_N);
			analog_ctrl_r.slew_rate_bit0      <= 1'(`RST_LINE_TEST >> `BIT_SLEW_B0);
			analog_ctrl_r.slew_rate_bit1      <= 1'(`RST_LINE_TEST >> `BIT_SLEW_B1);
			analog_ctrl_r.bandgap_trim        <= 4'(`RST_REF_TRIM >> `LSB_BANDGAP_TRIM);
		end else begin
			analog_ctrl_r <= ctrl_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Regulator short handling
	// ------------------------------------------------------------------
	logic short_flag_n_r;

	regulator_short_guard u_short_guard (
		.clk_sys                  (clk_sys),
		.sys_rst                  (sys_rst),
		.short_detect             (short_detect),
		.auto_shutdown_disable    (bank_r[6][`BIT_AUTO_SD_DIS]),
		.regulator_short_flag_n_r (short_flag_n_r),
		.regulator_powerdown_r    (regulator_powerdown_r)
	);

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	// The short flag bit is live status; a host write there is stored but
	// never seen, since the reader always shows the detector.
	logic [7:0] rd_word;

	always_comb begin
		rd_word = `RST_UNMAPPED_READ;
		if (rd_hit) begin
			rd_word = bank_r[req_idx];
			if (req_idx == idx_short)
				rd_word[`BIT_SHORT_FLAG_N] = short_flag_n_r;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			reg_rd_data_r  <= 8'h00;
			reg_rd_valid_r <= 1'b0;
			reg_hit_r      <= 1'b0;
		end else begin
			reg_rd_data_r  <= rd_word;
			reg_rd_valid_r <= rd_any;
			reg_hit_r      <= rd_hit;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	chk_pll_divider_hold: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		(wr_hit && req_idx == idx_pll)
		|=> (analog_ctrl_r.pll_divider_reset_n == $past(reg_req.wr_data[4]))
	) else $error("PLL divider reset does not follow its bit");

	chk_test_current_gate: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		!analog_ctrl_r.pll_current_test_enable
		|-> (analog_ctrl_r.pll_test_current_code == 8'h00)
	) else $error("Test current applied outside test mode");

	chk_test_current_pass: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		analog_ctrl_r.pll_current_test_enable
		|-> (analog_ctrl_r.pll_test_current_code == bank_r[4])
	) else $error("Test current code differs from register");

	chk_detector_gate: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		analog_ctrl_r.pll_detector_test_powerdown
		|-> (analog_ctrl_r.pll_current_test_enable && bank_r[5][0])
	) else $error("Detector powered down without test mode");

	chk_line_bits_order: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		1'b1 |-> ({analog_ctrl_r.first_stage_load_bit0, analog_ctrl_r.first_stage_load_bit1,
			analog_ctrl_r.slew_rate_bit0, analog_ctrl_r.slew_rate_bit1} == bank_r[8][3:0])
	) else $error("Line driver bits out of order");

	chk_trim_nibbles: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		1'b1 |-> ({analog_ctrl_r.bandgap_trim, analog_ctrl_r.common_voltage_trim} == bank_r[1])
	) else $error("Trim nibbles differ from register");

	chk_reset_defaults: assert property (
		@(posedge clk_sys)
		$fell(sys_rst) |-> (bank_r[1] == 8'h40 && bank_r[3] == 8'h10 && bank_r[8] == 8'h03
			&& analog_ctrl_r.slew_rate_bit0 && analog_ctrl_r.pll_divider_reset_n)
	) else $error("Bank left reset with wrong defaults");

	chk_reserved_readback: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		(wr_hit && req_idx == 4'h0) ##1 !reg_req.wr_en
		##1 (rd_hit && req_idx == 4'h0 && !reg_req.wr_en)
		|=> (reg_rd_data_r == $past(reg_req.wr_data, 3))
	) else $error("Reserved byte did not return written value");

	chk_override_bits: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		1'b1 |-> (analog_ctrl_r.powerdown_override == bank_r[9][5:0])
	) else $error("Power-down overrides differ from register");

	chk_unmapped_read: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		(reg_req.rd_en && !req_hit) |=> (reg_rd_valid_r && !reg_hit_r && reg_rd_data_r == 8'h00)
	) else $error("Unmapped read returned data");

endmodule : analog_trim_bank

// ==== test/trim_host_model.sv ====
/*
 * Host side of the bank's byte request port: one request per call, a read, a write or both at once.
 * Assumes the bank answers a read exactly one cycle after taking it.
 */
`timescale 1ns/10ps

module trim_host_model (
	input  wire logic                 clk_sys,
	output analog_trim_pkg::reg_req_t reg_req,
	input  wire logic [7:0]           rd_data,
	input  wire logic                 rd_valid,
	input  wire logic                 hit
);
	// ------------------------------------------------------------------
	// Access
	// ------------------------------------------------------------------
	initial reg_req = '0;

	// Released bus shows inverted values so a stale address never passes
	task automatic access(input logic [7:0] a, input logic w, input logic r,
		input logic [7:0] d, output logic [7:0] q, output logic v, output logic h);
		@(posedge clk_sys);
		reg_req <= '{addr: a, wr_en: w, rd_en: r, wr_data: d};
		@(posedge clk_sys);
		reg_req <= '{addr: ~a, wr_en: 1'b0, rd_en: 1'b0, wr_data: ~d};
		#1;
		q = rd_data;
		v = rd_valid;
		h = hit;
	endtask : access
endmodule : trim_host_model

// ==== test/analog_trim_test_register_bank_tb.sv ====
/*
 * Self-checking bench for the analog trim register bank.
 * Assumes the host model drives the request port; short_detect driven here.
 */
`timescale 1ns/10ps

module analog_trim_test_register_bank_tb;
	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	localparam int LIMIT = 20000;
	localparam logic [7:0] DEF [25:34] = '{8'h00, 8'h40, 8'h00, 8'h10, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
	logic                          clk_sys;
	logic                          sys_rst = 1'b1;
	logic                          short_detect = 1'b0;
	analog_trim_pkg::reg_req_t     reg_req;
	logic [7:0]                    rd_data;
	logic                          rd_valid;
	logic                          hit;
	logic                          pwr_down;
	analog_trim_pkg::analog_ctrl_t ctrl;
	logic [7:0]                    img [25:34];
	logic [7:0]                    q;
	logic                          v;
	logic                          h;
	int                            n_fail = 0;
	int                            comparisons = 0;
	int                            cyc = 0;

	analog_trim_bank i_analog_trim_bank (
		.clk_sys               (clk_sys),
		.sys_rst               (sys_rst),
		.reg_req               (reg_req),
		.short_detect          (short_detect),
		.reg_rd_data_r         (rd_data),
		.reg_rd_valid_r        (rd_valid),
		.reg_hit_r             (hit),
		.analog_ctrl_r         (ctrl),
		.regulator_powerdown_r (pwr_down)
	);

	trim_host_model i_trim_host_model (
		.clk_sys  (clk_sys),
		.reg_req  (reg_req),
		.rd_data  (rd_data),
		.rd_valid (rd_valid),
		.hit      (hit)
	);

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// ------------------------------------------------------------------
	// Expectations and comparisons
	// ------------------------------------------------------------------
	function automatic analog_trim_pkg::analog_ctrl_t exp_ctrl();
		analog_trim_pkg::analog_ctrl_t c;
		logic t;
		t = img[28][1];
		c.pll_divider_reset_n = img[28][4];
		c.pll_current_test_enable = t;
		c.pll_fast_freerun_select = img[28][0];
		c.pll_test_current_code = t ? img[29] : 8'h00;
		c.pll_detector_test_powerdown = img[30][0] & t;
		c.undervoltage_threshold_select = img[32][1];
		c.undervoltage_reference_select = img[32][0];
		c.first_stage_load_bit0 = img[33][3];
		c.first_stage_load_bit1 = img[33][2];
		c.slew_rate_bit0 = img[33][1];
		c.slew_rate_bit1 = img[33][0];
		c.common_voltage_trim = img[26][3:0];
		c.bandgap_trim = img[26][7:4];
		c.powerdown_override = img[34][5:0];
		return c;
	endfunction : exp_ctrl

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t byte got %h exp %h", $time, got, exp);
		end
	endtask : chk_byte

	task automatic chk_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t flag got %b exp %b", $time, got, exp);
		end
	endtask : chk_bit

	task automatic chk_ctrl(input analog_trim_pkg::analog_ctrl_t got);
		comparisons++;
		if (got !== exp_ctrl()) begin
			n_fail++;
			$display("[ERR] %0t controls got %h exp %h", $time, got, exp_ctrl());
		end
	endtask : chk_ctrl

	// ------------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_trim_host_model.access(a, 1'b1, 1'b0, d, q, v, h);
		if (a >= 8'h19 && a <= 8'h22) begin
			img[a] = d;
		end
		chk_ctrl(ctrl);
	endtask : wr

	// Flag bit is live: short_detect is held steady around every read
	task automatic rd(input logic [7:0] a);
		logic m;
		m = a >= 8'h19 && a <= 8'h22;
		i_trim_host_model.access(a, 1'b0, 1'b1, 8'h00, q, v, h);
		chk_bit(v, 1'b1);
		chk_bit(h, m);
		if (a == 8'h1f) begin
			chk_byte(q, {img[31][7:5], ~short_detect, img[31][3:0]});
		end else begin
			chk_byte(q, m ? img[a] : 8'h00);
		end
	endtask : rd

	task automatic do_reset();
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		#1;
		foreach (img[i]) begin
			img[i] = DEF[i];
		end
		chk_ctrl(ctrl);
		chk_bit(pwr_down, 1'b0);
		for (int a = 25; a <= 34; a++) begin
			rd(8'(a));
		end
	endtask : do_reset

	task automatic give_verdict();
		$display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict

	// Generous ceiling: the whole sequence needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_fail++;
			$display("[ERR] %0t timeout", $time);
			give_verdict();
		end
	end

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial begin
		do_reset();
		$display("test defaults done");
		for (int a = 25; a <= 34; a++) begin
			wr(8'(a), 8'ha5);
			rd(8'(a));
			wr(8'(a), 8'h5a);
			rd(8'(a));
		end
		$display("test patterns done");
		wr(8'h1d, 8'hff);
		wr(8'h1e, 8'h01);
		wr(8'h1c, 8'h00);
		wr(8'h1c, 8'h13);
		wr(8'h1c, 8'h11);
		for (int i = 0; i < 4; i++) begin
			wr(8'h21, 8'(1 << i));
		end
		for (int i = 0; i < 4; i++) begin
			wr(8'h20, 8'(i));
		end
		wr(8'h22, 8'hff);
		rd(8'h22);
		$display("test fields done");
		rd(8'h18);
		rd(8'h23);
		wr(8'h23, 8'hff);
		wr(8'h18, 8'hff);
		rd(8'h19);
		rd(8'h22);
		// Write and read in one request: old value comes back
		i_trim_host_model.access(8'h1d, 1'b1, 1'b1, 8'h3c, q, v, h);
		chk_byte(q, img[29]);
		img[29] = 8'h3c;
		rd(8'h1d);
		$display("test access done");
		wr(8'h1f, 8'h00);
		@(posedge clk_sys);
		short_detect <= 1'b1;
		@(posedge clk_sys);
		#1;
		chk_bit(pwr_down, 1'b1);
		rd(8'h1f);
		@(posedge clk_sys);
		short_detect <= 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		chk_bit(pwr_down, 1'b1);
		wr(8'h1f, 8'h01);
		@(posedge clk_sys);
		#1;
		chk_bit(pwr_down, 1'b0);
		@(posedge clk_sys);
		short_detect <= 1'b1;
		repeat (5) @(posedge clk_sys);
		#1;
		chk_bit(pwr_down, 1'b0);
		rd(8'h1f);
		@(posedge clk_sys);
		short_detect <= 1'b0;
		$display("test short done");
		wr(8'h21, 8'h00);
		do_reset();
		$display("test reset done");
		give_verdict();
	end
endmodule : analog_trim_test_register_bank_tb
